// ===== rtl/ssr_handler.sv
// standard set-request handler for the default control pipe
// Operation
// [R1] set address: type zero, address in wValue
// [R2] status stage opposite data, else to host
// [R3] old address kept through whole transfer
// [R4] new address only after status completes
// [R5] finish other operations before status stage
// [R6] host keeps address below 128, zero fields
// [R7] default: nonzero address enters address state
// [R8] address: zero address returns to default
// [R9] configuration value in low byte of wValue
// [R10] address state: zero stays, match configures
// [R11] configured: zero to address, match stays
// [R12] descriptor type high byte, index low byte
// [R13] wIndex language id, wLength byte count
// [R14] descriptor write: device, config, string only
// [R15] feature selector must fit the recipient
// [R16] test mode: device recipient, selector high byte
// [R17] selectors one to five valid, others error
// [R18] enter test after status, within 3 ms
// [R19] test mode held until power cycle
// [R20] test mode accepted in every state
// [R21] unknown feature stalls the status stage
// [R22] missing interface or endpoint is an error
// [R23] each good configuration clears endpoint halts
// [R24] request error shown as stall handshake
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module ssr_handler #(
   parameter int TEST_CYC = ssr_pkg::TEST_ENTRY_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // setup packet from the packet engine
   input wire logic setup_valid,
   input wire logic [7:0] bm_request_type,
   input wire logic [7:0] b_request,
   input wire logic [15:0] w_value,
   input wire logic [15:0] w_index,
   input wire logic [15:0] w_length,
   // stage events
   input wire logic status_done,
   input wire logic desc_done,
   input wire logic bus_reset,
   // answer to the control transfer
   output logic req_ack,
   output logic req_stall,
   output logic status_in,
   output logic desc_go,
   // device state
   output logic [6:0] dev_addr,
   output logic [2:0] dev_state,
   output logic [7:0] config_value,
   output logic halt_clear,
   output logic ep_halt_set,
   output logic [3:0] ep_halt_num,
   output logic wakeup_en,
   output logic test_on,
   output logic [2:0] test_sel
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      ssr_pkg::ssr_state_e st;
      logic [6:0] addr;
      logic [6:0] pend_addr;
      logic addr_pend;
      logic [7:0] cfg;
      logic test_pend;
      logic test_arm;
      logic test_on;
      logic [2:0] test_sel;
      logic [19:0] tcnt;
      logic wake;
      logic ack;
      logic stall;
      logic stat_in;
      logic desc_wait;
      logic desc_go;
      logic halt_clr;
      logic ep_halt;
      logic [3:0] ep_num;
      logic [31:0] ctrl;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ssr_regs_s;

   ssr_regs_s r;
   ssr_regs_s n;

   // ----------------------------------------
   // control fields
   // ----------------------------------------
   logic desc_en;
   logic wake_cap;
   logic [7:0] ncfg;
   logic [3:0] nif;
   logic [3:0] nep;
   logic [7:0] tsel_raw;
   logic [3:0] ep_idx;
   logic in_dflt;
   logic in_addr;
   logic [31:0] stat_word;

   assign desc_en = r.ctrl[ssr_pkg::CTRL_DESC_EN];
   assign wake_cap = r.ctrl[ssr_pkg::CTRL_WAKE_CAP];
   assign ncfg = r.ctrl[ssr_pkg::CTRL_NCFG_LSB +: 8];
   assign nif = r.ctrl[ssr_pkg::CTRL_NIF_LSB +: 4];
   assign nep = r.ctrl[ssr_pkg::CTRL_NEP_LSB +: 4];
   assign tsel_raw = w_index[15:8];
   assign ep_idx = w_index[3:0];
   assign in_dflt = (r.st == ssr_pkg::DS_DEFAULT);
   assign in_addr = (r.st == ssr_pkg::DS_ADDRESS);

   // status word seen by software
   always_comb begin
      stat_word = 32'h00000000;
      stat_word[ssr_pkg::STAT_STATE_LSB +: 3] = r.st;
      stat_word[ssr_pkg::STAT_ADDR_LSB +: 7] = r.addr;
      stat_word[ssr_pkg::STAT_CFG_LSB +: 8] = r.cfg;
      stat_word[ssr_pkg::STAT_TSEL_LSB +: 3] = r.test_sel;
      stat_word[ssr_pkg::STAT_TEST_ON] = r.test_on;
      stat_word[ssr_pkg::STAT_WAKE] = r.wake;
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      n = r;
      n.halt_clr = 1'b0;
      n.ep_halt = 1'b0;
      n.desc_go = 1'b0;
      n.pready = 1'b0;
      n.pslverr = 1'b0;

      // apb: one wait state, write lands on the completing edge
      if (psel && penable && !r.pready) begin
         n.pready = 1'b1;
         n.prdata = 32'h00000000;
         if (paddr == ssr_pkg::OFS_CTRL) begin
            n.prdata = r.ctrl;
         end else if (paddr == ssr_pkg::OFS_STAT) begin
            n.prdata = stat_word;
         end else begin
            n.pslverr = 1'b1;
         end
      end
      if (psel && penable && r.pready && pwrite && paddr == ssr_pkg::OFS_CTRL) begin
         n.ctrl = pwdata & ssr_pkg::CTRL_MASK;
      end

      // test entry: count from acceptance, never before the status stage
      if (r.test_pend) begin
         if (r.tcnt < 20'(TEST_CYC - 1)) begin
            n.tcnt = r.tcnt + 20'h00001;
         end else if (r.test_arm) begin
            n.test_pend = 1'b0;
            n.test_arm = 1'b0;
            n.test_on = 1'b1; // [R18]
         end
      end

      // data stage of a descriptor write finished
      if (r.desc_wait && desc_done) begin
         n.desc_wait = 1'b0;
         n.ack = 1'b1; // [R5]
      end

      // completion of the status stage
      if (status_done && !r.test_on) begin
         n.ack = 1'b0;
         n.stall = 1'b0;
         if (r.addr_pend) begin
            n.addr_pend = 1'b0;
            n.addr = r.pend_addr; // [R4]
            if (r.pend_addr != 7'h00) begin
               n.st = ssr_pkg::DS_ADDRESS; // [R7] [R8]
            end else begin
               n.st = ssr_pkg::DS_DEFAULT; // [R8]
            end
         end
         // status of the test request done: entry may now follow
         if (r.test_pend) begin
            n.test_arm = 1'b1; // [R18]
         end
      end

      // bus reset; test mode ignores all traffic
      if (bus_reset && !r.test_on && !r.test_arm) begin // [R19]
         n.st = ssr_pkg::DS_DEFAULT;
         n.test_pend = 1'b0;
         n.test_arm = 1'b0;
         n.addr = 7'h00;
         n.cfg = 8'h00;
         n.wake = 1'b0;
         n.addr_pend = 1'b0;
         n.ack = 1'b0;
         n.stall = 1'b0;
         n.desc_wait = 1'b0;
      end else if (setup_valid && !r.test_on && !r.test_arm) begin
         // new setup drops the previous answer; address unchanged [R3]
         n.ack = 1'b0;
         // an unconfirmed test entry is dropped as well
         n.test_pend = 1'b0;
         n.test_arm = 1'b0;
         n.stall = 1'b0;
         n.addr_pend = 1'b0;
         n.desc_wait = 1'b0;
         n.stat_in = (w_length == 16'h0000) || !bm_request_type[7]; // [R2]
         unique case (b_request)
            ssr_pkg::REQ_SET_ADDRESS: begin
               // fields checked only as far as the address width [R1] [R6]
               if (bm_request_type == ssr_pkg::RT_DEVICE && !r.st[2]) begin
                  n.pend_addr = w_value[6:0];
                  n.addr_pend = 1'b1;
                  n.ack = 1'b1;
               end else begin
                  n.stall = 1'b1; // [R24]
               end
            end
            ssr_pkg::REQ_SET_CONFIG: begin
               if (in_dflt || bm_request_type != ssr_pkg::RT_DEVICE) begin
                  n.stall = 1'b1;
               end else if (w_value[7:0] == 8'h00) begin // [R9]
                  n.cfg = 8'h00;
                  n.st = ssr_pkg::DS_ADDRESS; // [R10] [R11]
                  n.halt_clr = 1'b1; // [R23]
                  n.ack = 1'b1;
               end else if (w_value[7:0] <= ncfg) begin
                  n.cfg = w_value[7:0];
                  n.st = ssr_pkg::DS_CONFIGURED; // [R10] [R11]
                  n.halt_clr = 1'b1; // [R23]
                  n.ack = 1'b1; // [R5]
               end else begin
                  n.stall = 1'b1; // [R10] [R11] [R24]
               end
            end
            ssr_pkg::REQ_SET_DESC: begin
               // device index zero, config index in range, string any [R12] [R13]
               if (desc_en && !in_dflt && bm_request_type == ssr_pkg::RT_DEVICE &&
                   ((w_value[15:8] == ssr_pkg::DT_DEVICE && w_value[7:0] == 8'h00 &&
                     w_index == 16'h0000) ||
                    (w_value[15:8] == ssr_pkg::DT_CONFIG && w_value[7:0] < ncfg &&
                     w_index == 16'h0000) ||
                    (w_value[15:8] == ssr_pkg::DT_STRING))) begin
                  n.desc_go = 1'b1; // [R14]
                  n.desc_wait = 1'b1;
               end else begin
                  n.stall = 1'b1; // [R14] [R24]
               end
            end
            ssr_pkg::REQ_SET_FEATURE: begin
               unique case (bm_request_type)
                  ssr_pkg::RT_DEVICE: begin
                     if (w_value == ssr_pkg::FS_TEST && w_index[7:0] == 8'h00 &&
                         tsel_raw >= ssr_pkg::TSEL_FIRST &&
                         tsel_raw <= ssr_pkg::TSEL_LAST) begin
                        n.test_sel = tsel_raw[2:0]; // [R16] [R17] [R20]
                        n.test_pend = 1'b1;
                        n.tcnt = 20'h00000;
                        n.ack = 1'b1;
                     end else if (w_value == ssr_pkg::FS_WAKEUP && wake_cap && !in_dflt) begin
                        n.wake = 1'b1; // [R15]
                        n.ack = 1'b1;
                     end else begin
                        n.stall = 1'b1; // [R17] [R21]
                     end
                  end
                  ssr_pkg::RT_EP: begin
                     if (w_value != ssr_pkg::FS_EP_HALT || in_dflt || ep_idx >= nep ||
                         (in_addr && ep_idx != 4'h0) || w_index[15:4] != 12'h000) begin
                        n.stall = 1'b1; // [R15] [R21] [R22]
                     end else begin
                        n.ep_halt = 1'b1;
                        n.ep_num = ep_idx;
                        n.ack = 1'b1;
                     end
                  end
                  default: begin
                     // no interface features exist; missing ones also error
                     n.stall = 1'b1; // [R21] [R22]
                     if (w_index[7:0] >= {4'h0, nif}) begin
                        n.stall = 1'b1; // [R22]
                     end
                  end
               endcase
            end
            default: begin
               // other requests are served elsewhere
            end
         endcase
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.st <= ssr_pkg::DS_DEFAULT;
         r.ctrl <= ssr_pkg::CTRL_RESET;
      end else begin
         r <= n;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign req_ack = r.ack;
   assign req_stall = r.stall;
   assign status_in = r.stat_in;
   assign desc_go = r.desc_go;
   assign dev_addr = r.addr;
   assign dev_state = r.st;
   assign config_value = r.cfg;
   assign halt_clear = r.halt_clr;
   assign ep_halt_set = r.ep_halt;
   assign ep_halt_num = r.ep_num;
   assign wakeup_en = r.wake;
   assign test_on = r.test_on;
   assign test_sel = r.test_sel;

endmodule // ssr_handler

`default_nettype wire

// ===== rtl/ssr_pkg.sv
// constants for the standard set-request handler
package ssr_pkg;
   // ----------------------------------------
   // request fields
   // ----------------------------------------
   localparam logic [7:0] RT_DEVICE = 8'h00;
   localparam logic [7:0] RT_IFACE = 8'h01;
   localparam logic [7:0] RT_EP = 8'h02;
   localparam logic [7:0] REQ_SET_FEATURE = 8'h03;
   localparam logic [7:0] REQ_SET_ADDRESS = 8'h05;
   localparam logic [7:0] REQ_SET_DESC = 8'h07;
   localparam logic [7:0] REQ_SET_CONFIG = 8'h09;
   localparam logic [15:0] FS_EP_HALT = 16'h0000;
   localparam logic [15:0] FS_WAKEUP = 16'h0001;
   localparam logic [15:0] FS_TEST = 16'h0002;
   localparam logic [7:0] DT_DEVICE = 8'h01;
   localparam logic [7:0] DT_CONFIG = 8'h02;
   localparam logic [7:0] DT_STRING = 8'h03;
   localparam logic [7:0] TSEL_FIRST = 8'h01;
   localparam logic [7:0] TSEL_LAST = 8'h05;
   localparam int ADDR_MAX = 127;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_STAT = 12'h004;
   localparam int CTRL_DESC_EN = 0;
   localparam int CTRL_WAKE_CAP = 1;
   localparam int CTRL_NCFG_LSB = 8;
   localparam int CTRL_NIF_LSB = 16;
   localparam int CTRL_NEP_LSB = 20;
   localparam logic [31:0] CTRL_MASK = 32'h00FFFF03;
   localparam logic [31:0] CTRL_RESET = 32'h00110100;
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_ADDR_LSB = 8;
   localparam int STAT_CFG_LSB = 16;
   localparam int STAT_TSEL_LSB = 24;
   localparam int STAT_TEST_ON = 27;
   localparam int STAT_WAKE = 28;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int TEST_ENTRY_MS = 3;
   localparam int TEST_ENTRY_CYC = TEST_ENTRY_MS * 1000 * CLK_MHZ;

   // ----------------------------------------
   // device states
   // ----------------------------------------
   typedef enum logic [2:0] {
      DS_DEFAULT = 3'b001,
      DS_ADDRESS = 3'b010,
      DS_CONFIGURED = 3'b100
   } ssr_state_e;
endpackage

// ===== verif/ssr_handler_sva.sv
// assertion checker for the set-request handler
`timescale 1ns/1ps
`default_nettype none
module ssr_handler_sva #(
   parameter int TEST_CYC = 8
) (
   // clock, reset and setup side
   input wire logic pclk,
   input wire logic presetn,
   input wire logic setup_valid,
   input wire logic [7:0] bm_request_type,
   input wire logic [7:0] b_request,
   input wire logic [15:0] w_value,
   input wire logic [15:0] w_index,
   input wire logic status_done,
   input wire logic bus_reset,
   // answers and device state
   input wire logic req_ack,
   input wire logic req_stall,
   input wire logic status_in,
   input wire logic [6:0] dev_addr,
   input wire logic [2:0] dev_state,
   input wire logic [7:0] config_value,
   input wire logic halt_clear,
   input wire logic test_on,
   input wire logic [2:0] test_sel
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic tk;
   logic sdone;
   logic [7:0] lreq;
   logic [6:0] lval;
   logic [2:0] lsel;
   int tcnt;
   assign tk = setup_valid && !bus_reset && !test_on;
   // last taken request and test-entry timer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {lreq, lval, lsel, tcnt, sdone} <= '0;
      end else begin
         if (tk) begin
            {lreq, lval, lsel} <= {b_request, w_value[6:0], w_index[10:8]};
         end
         if (tk && b_request == ssr_pkg::REQ_SET_FEATURE && w_value == ssr_pkg::FS_TEST) begin
            {tcnt, sdone} <= {32'h1, 1'b0};
         end else begin
            {tcnt, sdone} <= {tcnt + 1, sdone | status_done};
         end
      end
   end
   property p_ack_addr;
      tk && b_request == ssr_pkg::REQ_SET_ADDRESS && dev_state != ssr_pkg::DS_CONFIGURED
         |=> req_ack && status_in && $stable(dev_addr);
   endproperty
   a_ack_addr: assert property (p_ack_addr) else $error("set address answer wrong");
   property p_addr_go;
      status_done && req_ack && !setup_valid && !bus_reset && lreq == ssr_pkg::REQ_SET_ADDRESS
         |=> dev_addr == lval && dev_state == (lval != 0 ? ssr_pkg::DS_ADDRESS : ssr_pkg::DS_DEFAULT);
   endproperty
   a_addr_go: assert property (p_addr_go) else $error("address not taken after status");
   property p_hold;
      req_ack && !status_done && !bus_reset |=> $stable(dev_addr);
   endproperty
   a_hold: assert property (p_hold) else $error("address moved before status");
   property p_cfg0;
      tk && b_request == ssr_pkg::REQ_SET_CONFIG && dev_state != ssr_pkg::DS_DEFAULT && w_value[7:0] == 0
         |=> dev_state == ssr_pkg::DS_ADDRESS && config_value == 0 && req_ack;
   endproperty
   a_cfg0: assert property (p_cfg0) else $error("configuration zero mishandled");
   property p_halt;
      tk && b_request == ssr_pkg::REQ_SET_CONFIG && dev_state != ssr_pkg::DS_DEFAULT
         |=> halt_clear == req_ack && (req_ack ^ req_stall);
   endproperty
   a_halt: assert property (p_halt) else $error("halt clear wrong");
   property p_stall;
      tk && b_request == ssr_pkg::REQ_SET_FEATURE && (bm_request_type == ssr_pkg::RT_IFACE
         || (bm_request_type == ssr_pkg::RT_DEVICE && w_value == ssr_pkg::FS_TEST
         && (w_index[15:8] < ssr_pkg::TSEL_FIRST || w_index[15:8] > ssr_pkg::TSEL_LAST)))
         |=> (req_stall && !req_ack) [*2];
   endproperty
   a_stall: assert property (p_stall) else $error("bad feature not stalled");
   property p_test;
      $rose(test_on) |-> sdone && tcnt >= TEST_CYC && (tcnt <= TEST_CYC + 2 || $past(status_done, 2))
         && test_sel == lsel;
   endproperty
   a_test: assert property (p_test) else $error("test entry wrong");
   property p_keep;
      test_on |=> test_on && $stable(test_sel) && $stable(dev_addr);
   endproperty
   a_keep: assert property (p_keep) else $error("test mode left");
endmodule // ssr_handler_sva
bind ssr_handler ssr_handler_sva #(.TEST_CYC(TEST_CYC)) u_ssr_handler_sva (.*);
`default_nettype wire

// ===== verif/ssr_host_model.sv
// host-side model issuing control transfers
`timescale 1ns/1ps
`default_nettype none
module ssr_host_model (
   // clock
   input wire logic pclk,
   // setup packet
   output logic setup_valid = 1'b0,
   output wire logic [7:0] bm_request_type,
   output wire logic [7:0] b_request,
   output wire logic [15:0] w_value,
   output wire logic [15:0] w_index,
   output wire logic [15:0] w_length,
   // stage events
   output logic status_done = 1'b0,
   output logic desc_done = 1'b0,
   output logic bus_reset = 1'b0
);
   logic [71:0] f = '0;
   logic [7:0] cyc = 8'h00;
   // fields hold only with the strobe, a moving pattern otherwise
   always @(posedge pclk) cyc <= cyc + 8'h01;
   assign {bm_request_type, b_request, w_value, w_index, w_length} = setup_valid ? f : {9{cyc}};
   // one setup packet, one cycle long
   task automatic req(input logic [7:0] bm, r, input logic [15:0] wv, wi, wl);
      @(posedge pclk);
      setup_valid <= 1'b1;
      f <= {bm, r, wv, wi, wl};
      @(posedge pclk);
      setup_valid <= 1'b0;
   endtask
   // stage event: 0 status, 1 descriptor data, 2 bus reset
   task automatic pulse(input int k);
      @(posedge pclk);
      {bus_reset, desc_done, status_done} <= 3'h1 << k;
      @(posedge pclk);
      {bus_reset, desc_done, status_done} <= 3'h0;
   endtask
endmodule // ssr_host_model
`default_nettype wire

// ===== verif/tb_ssr_handler.sv
// self-checking bench for the set-request handler
`timescale 1ns/1ps
`default_nettype none
module tb_ssr_handler;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, q;
   logic setup_valid, status_done, desc_done, bus_reset, req_ack, req_stall, status_in, desc_go;
   logic halt_clear, ep_halt_set, wakeup_en, test_on;
   logic [7:0] bm_request_type, b_request, config_value;
   logic [15:0] w_value, w_index, w_length;
   logic [6:0] dev_addr;
   logic [2:0] dev_state, test_sel;
   logic [3:0] ep_halt_num;
   logic [7:0] sl[4] = '{8'h00, 8'h06, 8'h3F, 8'hC0};
   int cl[8] = '{3, 1, 2, 0, 0, 2, 2, 7};
   int err_total = 0, cmp_count = 0, m_st = 1, m_adr = 0, m_cfg = 0, ra, rb, n;
   integer seed = 32'h7a476ca6;
   ssr_handler #(.TEST_CYC(8)) u_ssr_handler (.*);
   ssr_host_model u_ssr_host_model (.*);
   always #2.5 pclk = ~pclk;
   // verdict and end of run
   task automatic close_out;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [39:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // apb transfer, waits for pready under a bound
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rq,
                      output logic re);
      n = 0;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_total++;
         close_out();
      end
      {rq, re} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask
   // control transfer against the integer model
   task automatic xfer(input logic [7:0] bm, r, input logic [15:0] wv, wi, input logic s, input int st, a, c);
      u_ssr_host_model.req(bm, r, wv, wi, 16'h0000);
      @(negedge pclk);
      chk({req_ack, req_stall, status_in | s, dev_addr}, {!s, s, 1'b1, m_adr[6:0]});
      {m_st, m_adr, m_cfg} = {st, a, c};
      if (!s) u_ssr_host_model.pulse(0);
      @(negedge pclk);
      chk({dev_state, dev_addr, config_value}, {m_st[2:0], m_adr[6:0], m_cfg[7:0]});
   endtask
   task automatic sa(input int a);
      xfer(8'h00, ssr_pkg::REQ_SET_ADDRESS, a[15:0], 16'h0000, 0, a ? 2 : 1, a, m_cfg);
   endtask
   task automatic sc(input int c);
      xfer(8'h00, ssr_pkg::REQ_SET_CONFIG, c[15:0], 16'h0000, c > 2, c > 2 ? m_st : (c ? 4 : 2), m_adr,
           c > 2 ? m_cfg : c);
   endtask
   task automatic sf(input logic [7:0] bm, input logic [15:0] wv, wi);
      xfer(bm, ssr_pkg::REQ_SET_FEATURE, wv, wi, 1, m_st, m_adr, m_cfg);
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 12'h000, 32'h00000000, q, e);
      chk({e, q}, {1'b0, ssr_pkg::CTRL_RESET});
      apb(1, 12'h000, 32'h00110203, q, e);
      apb(0, 12'h000, 32'h00000000, q, e);
      chk({e, q}, 33'h000110203);
      apb(1, 12'h004, 32'hFFFFFFFF, q, e);
      chk(e, 1'b0);
      apb(0, 12'h004, 32'h00000000, q, e);
      chk({e, q}, 33'h000000001);
      apb(0, 12'h008, 32'h00000000, q, e);
      chk({e, q}, 33'h100000000);
      $display("register test done");
      ra = ($random(seed) & 32'h7E) | 1;
      rb = ra ^ 32'h40;
      sa(0);
      sa(ra);
      sa(rb);
      sa(0);
      sa(rb);
      foreach (cl[i]) sc(cl[i]);
      $display("address and configuration test done");
      sf(ssr_pkg::RT_IFACE, 16'h0000, 16'h0000);
      sf(ssr_pkg::RT_EP, ssr_pkg::FS_EP_HALT, 16'h0001);
      foreach (sl[i]) sf(ssr_pkg::RT_DEVICE, ssr_pkg::FS_TEST, {sl[i], 8'h00});
      u_ssr_host_model.req(8'h00, ssr_pkg::REQ_SET_DESC, 16'h0300, 16'h0409, 16'h0004);
      @(negedge pclk);
      chk(desc_go, 1'b1);
      u_ssr_host_model.pulse(1);
      @(negedge pclk);
      chk({req_ack, req_stall}, 2'b10);
      u_ssr_host_model.pulse(0);
      xfer(8'h00, ssr_pkg::REQ_SET_DESC, 16'h0400, 16'h0000, 1, m_st, m_adr, m_cfg);
      u_ssr_host_model.req(ssr_pkg::RT_EP, ssr_pkg::REQ_SET_FEATURE, ssr_pkg::FS_EP_HALT, 16'h0000, 16'h0000);
      @(negedge pclk);
      chk({ep_halt_set, ep_halt_num, req_ack, req_stall}, {1'b1, 4'h0, 2'b10});
      u_ssr_host_model.pulse(0);
      xfer(ssr_pkg::RT_DEVICE, ssr_pkg::REQ_SET_FEATURE, ssr_pkg::FS_WAKEUP, 16'h0000, 0, m_st, m_adr, m_cfg);
      chk(wakeup_en, 1'b1);
      u_ssr_host_model.pulse(2);
      @(negedge pclk);
      m_st = 1;
      m_adr = 0;
      m_cfg = 0;
      chk({dev_state, dev_addr, config_value, wakeup_en, req_ack}, {3'h1, 7'h00, 8'h00, 2'b00});
      $display("feature and descriptor test done");
      xfer(8'h00, ssr_pkg::REQ_SET_FEATURE, ssr_pkg::FS_TEST, 16'h0400, 0, m_st, m_adr, m_cfg);
      n = 0;
      while (test_on !== 1'b1 && n < 40) begin
         @(negedge pclk);
         n++;
      end
      chk({test_on, test_sel}, 4'hC);
      u_ssr_host_model.req(8'h00, ssr_pkg::REQ_SET_ADDRESS, 16'h0005, 16'h0000, 16'h0000);
      u_ssr_host_model.pulse(0);
      @(negedge pclk);
      chk({test_on, dev_addr, req_ack}, {1'b1, m_adr[6:0], 1'b0});
      $display("test mode test done");
      close_out();
   end
endmodule // tb_ssr_handler
`default_nettype wire
